// ---- design/mid_pkg.sv ----
// Purpose: shared types and constants of the instruction decode core
// Assumes: one E-cycle per mclk; memory answers within the cycle
// Notes: opcode names cover only codes the core executes specially
package mid_pkg;
  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned REF_INPUT_HZ = 4_000_000;  // Gives 1 us E-cycles
  localparam int unsigned REF_E_DIV    = 4;
  localparam int unsigned MCLK_PER_E   = 1;

  typedef enum logic [2:0] {
    inherent_mode, immediate_mode, direct_mode,
    extended_mode, base_plus_offset_mode, pc_offset_mode
  } mid_mode_t;

  typedef struct packed {
    logic       valid;
    logic       test;
    mid_mode_t  mode;
    logic [1:0] len;
    logic [3:0] ncyc;
    logic       wide;
    logic       mem_rd;
    logic       mem_wr;
    logic [1:0] nbytes;
  } mid_dec_t;

  typedef struct packed {
    logic [15:0] addr;
    logic        rd;
    logic        wr;
    logic [7:0]  wdata;
  } mid_bus_t;

  typedef struct packed {
    logic [7:0]  a;
    logic [7:0]  b;
    logic [15:0] x;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [7:0]  ccr;
  } mid_regs_t;

  localparam int CCR_C = 0;
  localparam int CCR_V = 1;
  localparam int CCR_Z = 2;
  localparam int CCR_N = 3;
  localparam int CCR_I = 4;
  localparam logic [1:0]  CCR_ONES  = 2'b11;
  localparam logic [15:0] PC_RESET  = 16'h0000;
  localparam logic [15:0] SP_RESET  = 16'h0000;
  localparam logic [15:0] X_RESET   = 16'h0000;
  localparam logic [7:0]  ACC_RESET = 8'h00;
  localparam logic [7:0]  CCR_RESET = 8'hD0;
  localparam logic [15:0] IDLE_ADDR = 16'hFFFF;
  localparam logic [7:0]  TEST_OP_A = 8'h00;
  localparam logic [7:0]  TEST_OP_B = 8'h02;

  localparam logic [7:0] UNCONDITIONAL_BRANCH_OP = 8'h20;
  localparam logic [7:0] HARDWARE_MULTIPLY_OP    = 8'h3D;
  localparam logic [7:0] SOFTWARE_TRAP_OP        = 8'h3F;
  localparam logic [7:0] TRAP_RETURN_OP          = 8'h3B;
  localparam logic [7:0] HALT_UNTIL_IRQ_OP       = 8'h3E;
  localparam logic [7:0] OP_A_TO_CCR = 8'h06;
  localparam logic [7:0] OP_CCR_TO_A = 8'h07;
  localparam logic [7:0] OP_INC_X    = 8'h08;
  localparam logic [7:0] OP_DEC_X    = 8'h09;
  localparam logic [7:0] OP_CLR_V    = 8'h0A;
  localparam logic [7:0] OP_SET_V    = 8'h0B;
  localparam logic [7:0] OP_CLR_C    = 8'h0C;
  localparam logic [7:0] OP_SET_C    = 8'h0D;
  localparam logic [7:0] OP_CLR_I    = 8'h0E;
  localparam logic [7:0] OP_SET_I    = 8'h0F;
  localparam logic [7:0] OP_A_TO_B   = 8'h16;
  localparam logic [7:0] OP_B_TO_A   = 8'h17;
  localparam logic [7:0] OP_SP_TO_X  = 8'h30;
  localparam logic [7:0] OP_INC_SP   = 8'h31;
  localparam logic [7:0] OP_DEC_SP   = 8'h34;
  localparam logic [7:0] OP_X_TO_SP  = 8'h35;
  localparam logic [7:0] OP_ADD_B_X  = 8'h3A;
  localparam logic [7:0] OP_CLEAR_A  = 8'h4F;
  localparam logic [7:0] OP_CLEAR_B  = 8'h5F;
  localparam logic [3:0] NIB_LOAD8   = 4'h6;
  localparam logic [3:0] NIB_STORE8  = 4'h7;
  localparam logic [3:0] NIB_LOADD   = 4'hC;
  localparam logic [3:0] NIB_STORED  = 4'hD;
  localparam logic [3:0] NIB_LOAD16  = 4'hE;
  localparam logic [3:0] NIB_STORE16 = 4'hF;
endpackage : mid_pkg

// ---- design/mid_decode.sv ----
// Purpose: opcode byte to mode, length, cycle count and bus needs
// Assumes: pure combinational lookup
// Notes: unassigned codes decode as one-byte two-cycle fillers
`timescale 1ns/1ps
`default_nettype none
module mid_decode import mid_pkg::*; (
  input  wire logic [7:0] op,  // Opcode byte
  output var  mid_dec_t   dec  // Decoded fields
);
  function automatic logic unassigned(input logic [7:0] o);
    return o inside {8'h00, 8'h02, 8'h03, 8'h12, 8'h13, 8'h14, 8'h15, 8'h18,
                     8'h1A, 8'h1C, 8'h1D, 8'h1E, 8'h1F, 8'h41, 8'h42, 8'h45,
                     8'h4B, 8'h4E, 8'h51, 8'h52, 8'h55, 8'h5B, 8'h5E, 8'h61,
                     8'h62, 8'h65, 8'h6B, 8'h71, 8'h72, 8'h75, 8'h7B, 8'h87,
                     8'h8F, 8'hC7, 8'hCD, 8'hCF};
  endfunction : unassigned

  function automatic logic [3:0] cycles(input logic [7:0] o);
    logic [3:0] lo;
    logic       big;
    lo  = o[3:0];
    big = (lo == 4'h3) || (!o[6] && (lo == 4'hC || lo == 4'hD));
    if (o == 8'h8D) return 4'h6;
    if (o[7:4] == 4'h2) return 4'h3;
    if (o[7:4] == 4'h6 || o[7:4] == 4'h7) return (lo == 4'hE) ? 4'h3 : 4'h6;
    if (!o[7]) begin
      unique case (o)
        8'h04, 8'h05, 8'h08, 8'h09, 8'h30, 8'h31, 8'h34, 8'h35, 8'h36, 8'h37,
        8'h3A:                            return 4'h3;
        8'h32, 8'h33, 8'h3C:              return 4'h4;
        8'h38, 8'h39:                     return 4'h5;
        TRAP_RETURN_OP, HARDWARE_MULTIPLY_OP: return 4'hA;
        HALT_UNTIL_IRQ_OP:                return 4'h9;
        SOFTWARE_TRAP_OP:                 return 4'hC;
        default:                          return 4'h2;
      endcase
    end
    if (o[5:4] == 2'b00) return big ? 4'h4 : (lo >= 4'hC) ? 4'h3 : 4'h2;
    return (o[5] ? 4'h4 : 4'h3) + (big ? 4'h2 : (lo >= 4'hC) ? 4'h1 : 4'h0);
  endfunction : cycles

  function automatic mid_mode_t mode_of(input logic [7:0] o);
    unique case (o[7:4])
      4'h2:             return pc_offset_mode;
      4'h6, 4'hA, 4'hE: return base_plus_offset_mode;
      4'h7, 4'hB, 4'hF: return extended_mode;
      4'h9, 4'hD:       return direct_mode;
      4'h8, 4'hC:       return (o == 8'h8D) ? pc_offset_mode : immediate_mode;
      default:          return inherent_mode;
    endcase
  endfunction : mode_of

  wire logic       bad   = unassigned(op);
  wire logic       tst   = (op == TEST_OP_A) || (op == TEST_OP_B);
  wire mid_mode_t  md    = bad ? inherent_mode : mode_of(op);
  wire logic [3:0] lo    = op[3:0];
  wire logic       wide  = op[7] && (lo == 4'h3 || (lo >= 4'hC && (op[6] || lo != 4'hD)));
  wire logic       memm  = md inside {direct_mode, base_plus_offset_mode, extended_mode};
  wire logic       jump  = (lo == 4'hE && !op[7]) || (lo == 4'hD && op[7] && !op[6]);
  wire logic       wr    = memm && op[7] && (lo == NIB_STORE8 || lo == NIB_STORE16
                                             || (lo == NIB_STORED && op[6]));
  wire logic       rd    = memm && !wr && !jump;
  wire logic [1:0] len   = (md == inherent_mode) ? 2'd1 :
                           (md == extended_mode) ? 2'd3 :
                           (md == immediate_mode && wide) ? 2'd3 : 2'd2;
  wire logic [1:0] nb    = (rd || wr) ? (wide ? 2'd2 : 2'd1) : 2'd0;
  wire logic [3:0] ncyc  = bad ? 4'h2 : cycles(op);

  assign dec = {!bad, tst, md, len, ncyc, wide && !bad, rd && !bad, wr && !bad,
                bad ? 2'd0 : nb};
endmodule : mid_decode
`default_nettype wire

// ---- design/mid_ea.sv ----
// Purpose: effective address from mode, operand bytes and index
// Assumes: operand bytes already gathered, high byte first
// Notes: indexed sum wraps at 16 bits
`timescale 1ns/1ps
`default_nettype none
module mid_ea import mid_pkg::*; (
  input  wire mid_mode_t   mode,  // Addressing mode
  input  wire logic [15:0] opv,   // Operand bytes
  input  wire logic [15:0] x,     // Index register
  output logic      [15:0] ea     // Effective address
);
  assign ea = (mode == direct_mode) ? {8'h00, opv[7:0]} :
              (mode == base_plus_offset_mode) ? x + {8'h00, opv[7:0]} :
              opv;
endmodule : mid_ea
`default_nettype wire

// ---- design/mid_core.sv ----
// Purpose: instruction sequencer and programming model
// Assumes: mem_rdata answers bus_o.addr in the same cycle
// Notes: stack pushes and most ALU operations only keep their timing
`timescale 1ns/1ps
`default_nettype none
module mid_core import mid_pkg::*; (
  input  wire logic       mclk,           // E-cycle clock
  input  wire logic       reset_n,        // Async reset, active low
  input  wire logic [7:0] mem_rdata,      // Read data of current access
  input  wire logic       irq_req,        // Maskable interrupt request
  output mid_bus_t        bus_o,          // Memory access of this cycle
  output mid_regs_t       regs_o,         // Architectural registers
  output mid_mode_t       mode_o,         // Mode decoded in the previous cycle
  output logic            instr_done_o,   // Instruction ended last cycle
  output logic            illegal_op_o,   // Unassigned opcode fetched
  output logic            test_mode_o,    // Free-running PC mode
  output logic            irq_unmasked_o  // Request passed through mask
);
  mid_bus_t    bus_reg;
  logic [3:0]  cyc_reg;
  logic [7:0]  op_reg;
  logic [15:0] val_reg;
  logic [15:0] ea_reg;
  logic [15:0] pc_reg;
  logic [15:0] x_reg;
  logic [15:0] sp_reg;
  logic [7:0]  a_reg;
  logic [7:0]  b_reg;
  logic [7:0]  ccr_reg;
  logic        test_reg;
  logic        done_reg;
  logic        illegal_reg;
  logic        irq_reg;
  mid_mode_t   mode_reg;
  logic [7:0]  a_next;
  logic [7:0]  b_next;
  logic [15:0] x_next;
  logic [15:0] sp_next;
  logic [7:0]  ccr_next;
  logic        pc_load;
  logic [15:0] pc_target;
  mid_dec_t    dec;
  logic [15:0] ea_c;

  function automatic logic br_cond(input logic [3:0] lo, input logic [7:0] c);
    logic n, z, v, cy, base;
    n  = c[CCR_N];
    z  = c[CCR_Z];
    v  = c[CCR_V];
    cy = c[CCR_C];
    unique case (lo[3:1])
      3'd0: base = 1'b1;
      3'd1: base = !(cy || z);
      3'd2: base = !cy;
      3'd3: base = !z;
      3'd4: base = !v;
      3'd5: base = !n;
      3'd6: base = !(n ^ v);
      3'd7: base = !(z || (n ^ v));
    endcase
    return base ^ lo[0];
  endfunction : br_cond

  // Loads and stores set N and Z from the moved value and clear V
  function automatic logic [7:0] nzv(input logic [7:0] c, input logic [15:0] v,
                                     input logic w);
    logic [7:0] r;
    r        = c;
    r[CCR_N] = w ? v[15] : v[7];
    r[CCR_Z] = w ? (v == 16'h0000) : (v[7:0] == 8'h00);
    r[CCR_V] = 1'b0;
    return r;
  endfunction : nzv

  wire logic       cyc0    = (cyc_reg == 4'h0);
  wire logic [7:0] op      = cyc0 ? mem_rdata : op_reg;

  mid_decode u_dec (
    .op  (op),
    .dec (dec)
  );

  wire logic [3:0]  len4    = {2'b00, dec.len};
  wire logic [3:0]  k1      = cyc_reg + 4'h1;
  wire logic        last    = (cyc_reg == dec.ncyc - 4'h1);
  wire logic        fetch   = (cyc_reg < len4);
  wire logic        rd_now  = bus_reg.rd && !cyc0;
  wire logic [15:0] val_now = rd_now ? {val_reg[7:0], mem_rdata} : val_reg;
  wire logic        ea_cap  = (cyc_reg == len4 - 4'h1);

  mid_ea u_ea (
    .mode (dec.mode),
    .opv  (val_now),
    .x    (x_reg),
    .ea   (ea_c)
  );

  wire logic        exec    = last && dec.valid && !dec.test && !test_reg;
  wire logic        in_mem1 = (k1 >= len4) && (k1 < len4 + {2'b00, dec.nbytes});
  wire logic [3:0]  off1    = k1 - len4;
  wire logic [15:0] ea_use  = ea_cap ? ea_c : ea_reg;
  wire logic [15:0] addr1   = ea_use + {15'h0000, off1[0]};
  wire logic [15:0] src16   = (op[3:0] == NIB_STORED) ? {a_reg, b_reg} :
                              (op[3:0] == NIB_STORE16) ? (op[6] ? x_reg : sp_reg) :
                              {8'h00, op[6] ? b_reg : a_reg};
  wire logic [7:0]  wdata1  = (dec.wide && !off1[0]) ? src16[15:8] : src16[7:0];
  wire logic [15:0] pc_seq  = fetch ? pc_reg + 16'h0001 : pc_reg;
  wire logic        go_test = test_reg || (cyc0 && dec.test);
  wire logic [15:0] pc_next = go_test ? pc_reg + 16'h0001 :
                              (exec && pc_load) ? pc_target : pc_seq;
  wire logic [15:0] off_sx  = {{8{val_reg[7]}}, val_reg[7:0]};
  wire logic [15:0] prod    = 16'(a_reg) * 16'(b_reg);
  wire logic [15:0] x_inc   = x_reg + 16'h0001;
  wire logic [15:0] x_dec   = x_reg - 16'h0001;

  // Idle cycles park the bus at a fixed address with no strobe
  wire mid_bus_t bus_next =
    (go_test || last || k1 < len4) ? {pc_next, 1'b1, 1'b0, 8'h00} :
    in_mem1 ? {addr1, dec.mem_rd, dec.mem_wr, dec.mem_wr ? wdata1 : 8'h00} :
    {IDLE_ADDR, 1'b0, 1'b0, 8'h00};

  always_comb begin
    a_next    = a_reg;
    b_next    = b_reg;
    x_next    = x_reg;
    sp_next   = sp_reg;
    ccr_next  = ccr_reg;
    pc_load   = 1'b0;
    pc_target = ea_use;
    if (exec && dec.mode == pc_offset_mode) begin
      pc_load   = (op == 8'h8D) || br_cond(op[3:0], ccr_reg);
      pc_target = pc_seq + off_sx;
    end else if (exec && (op == 8'h6E || op == 8'h7E || dec.nbytes == 2'd0)
                 && dec.mode != inherent_mode && dec.mode != immediate_mode) begin
      pc_load = 1'b1;
    end
    if (exec && op[7] && dec.mode != pc_offset_mode) begin
      unique case (op[3:0])
        NIB_LOAD8: begin
          if (op[6]) b_next = val_now[7:0];
          else a_next = val_now[7:0];
          ccr_next = nzv(ccr_reg, val_now, 1'b0);
        end
        NIB_STORE8: ccr_next = nzv(ccr_reg, src16, 1'b0);
        NIB_LOADD: if (op[6]) begin
          {a_next, b_next} = val_now;
          ccr_next = nzv(ccr_reg, val_now, 1'b1);
        end
        NIB_STORED: if (op[6]) ccr_next = nzv(ccr_reg, src16, 1'b1);
        NIB_LOAD16: begin
          if (op[6]) x_next = val_now;
          else sp_next = val_now;
          ccr_next = nzv(ccr_reg, val_now, 1'b1);
        end
        NIB_STORE16: ccr_next = nzv(ccr_reg, src16, 1'b1);
        default: ;
      endcase
    end
    if (exec && dec.mode == inherent_mode) begin
      unique case (op)
        OP_INC_X: begin x_next = x_inc; ccr_next[CCR_Z] = (x_inc == 16'h0000); end
        OP_DEC_X: begin x_next = x_dec; ccr_next[CCR_Z] = (x_dec == 16'h0000); end
        OP_INC_SP:  sp_next = sp_reg + 16'h0001;
        OP_DEC_SP:  sp_next = sp_reg - 16'h0001;
        OP_SP_TO_X: x_next = sp_reg + 16'h0001;
        OP_X_TO_SP: sp_next = x_dec;
        OP_ADD_B_X: x_next = x_reg + {8'h00, b_reg};
        OP_A_TO_B: begin b_next = a_reg; ccr_next = nzv(ccr_reg, {8'h00, a_reg}, 1'b0); end
        OP_B_TO_A: begin a_next = b_reg; ccr_next = nzv(ccr_reg, {8'h00, b_reg}, 1'b0); end
        OP_A_TO_CCR: ccr_next = {CCR_ONES, a_reg[5:0]};
        OP_CCR_TO_A: a_next = ccr_reg;
        OP_CLR_V: ccr_next[CCR_V] = 1'b0;
        OP_SET_V: ccr_next[CCR_V] = 1'b1;
        OP_CLR_C: ccr_next[CCR_C] = 1'b0;
        OP_SET_C: ccr_next[CCR_C] = 1'b1;
        OP_CLR_I: ccr_next[CCR_I] = 1'b0;
        OP_SET_I, SOFTWARE_TRAP_OP: ccr_next[CCR_I] = 1'b1;
        OP_CLEAR_A, OP_CLEAR_B: begin
          if (op[4]) b_next = 8'h00;
          else a_next = 8'h00;
          ccr_next = nzv(ccr_reg, 16'h0000, 1'b0);
          ccr_next[CCR_C] = 1'b0;
        end
        HARDWARE_MULTIPLY_OP: begin
          {a_next, b_next} = prod;
          ccr_next[CCR_C] = prod[7];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      bus_reg <= {PC_RESET, 1'b1, 1'b0, 8'h00};
      cyc_reg <= 4'h0;
      op_reg  <= 8'h00;
      val_reg <= 16'h0000;
      ea_reg  <= 16'h0000;
      pc_reg  <= PC_RESET;
    end else begin
      bus_reg <= bus_next;
      cyc_reg <= (go_test || last) ? 4'h0 : k1;
      op_reg  <= op;
      val_reg <= val_now;
      ea_reg  <= ea_cap ? ea_c : ea_reg;
      pc_reg  <= pc_next;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      a_reg   <= ACC_RESET;
      b_reg   <= ACC_RESET;
      x_reg   <= X_RESET;
      sp_reg  <= SP_RESET;
      ccr_reg <= CCR_RESET;
    end else begin
      a_reg   <= a_next;
      b_reg   <= b_next;
      x_reg   <= x_next;
      sp_reg  <= sp_next;
      ccr_reg <= {CCR_ONES, ccr_next[5:0]};
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      test_reg    <= 1'b0;
      done_reg    <= 1'b0;
      illegal_reg <= 1'b0;
      irq_reg     <= 1'b0;
      mode_reg    <= inherent_mode;
    end else begin
      test_reg    <= go_test;
      done_reg    <= last && !go_test;
      illegal_reg <= cyc0 && !dec.valid && !dec.test && !test_reg;
      irq_reg     <= irq_req && !ccr_reg[CCR_I];
      mode_reg    <= dec.mode;
    end
  end

  assign bus_o          = bus_reg;
  assign regs_o         = {a_reg, b_reg, x_reg, sp_reg, pc_reg, ccr_reg};
  assign mode_o         = mode_reg;
  assign instr_done_o   = done_reg;
  assign illegal_op_o   = illegal_reg;
  assign test_mode_o    = test_reg;
  assign irq_unmasked_o = irq_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_opcode_fetch: assert property (cyc0 && !test_reg
    |-> bus_reg.rd && bus_reg.addr == pc_reg)
    else $error("opcode not fetched at pc");
  a_pc_operand: assert property (fetch && !test_reg && !(exec && pc_load)
    |=> pc_reg == $past(pc_reg) + 16'h0001)
    else $error("pc did not step on operand fetch");
  a_test_count: assert property (test_reg |=> test_reg && bus_reg.rd
    && pc_reg == $past(pc_reg) + 16'h0001)
    else $error("test mode pc not counting");
  a_ccr_ones: assert property (regs_o.ccr[7:6] == CCR_ONES)
    else $error("unused ccr bits not one");
  a_direct_page: assert property (dec.mode == direct_mode && cyc_reg >= len4
    && (bus_reg.rd || bus_reg.wr) |-> bus_reg.addr[15:8] == 8'h00)
    else $error("direct access outside page zero");
  a_index_base: assert property (dec.mode == base_plus_offset_mode
    && cyc_reg == len4 && (bus_reg.rd || bus_reg.wr)
    |-> bus_reg.addr == x_reg + {8'h00, val_reg[7:0]} && $stable(x_reg))
    else $error("indexed address wrong");
  a_branch_time: assert property (cyc_reg == 4'h1 && op_reg[7:4] == 4'h2
    && !test_reg |-> ##2 cyc0)
    else $error("branch not three cycles");
  a_branch_target: assert property (exec && dec.mode == pc_offset_mode
    && pc_load |=> bus_reg.addr == $past(pc_reg) + $past(off_sx))
    else $error("branch target wrong");
  a_multiply_time: assert property (cyc_reg == 4'h1 && op_reg == HARDWARE_MULTIPLY_OP
    && !test_reg |-> ##9 cyc0 && {regs_o.a, regs_o.b} == $past(prod, 9))
    else $error("multiply timing or product wrong");
  a_trap_time: assert property (cyc_reg == 4'h1 && op_reg == SOFTWARE_TRAP_OP
    && !test_reg |-> ##11 cyc0 && regs_o.ccr[CCR_I])
    else $error("trap not twelve cycles");
  a_irq_mask: assert property (ccr_reg[CCR_I] |=> !irq_unmasked_o)
    else $error("interrupt passed while masked");
endmodule : mid_core
`default_nettype wire

// ---- test/mid_mem_model.sv ----
// Purpose: program and data memory on the far side of the core bus
// Assumes: asynchronous read, write taken at the edge ending a write cycle
// Notes: no wait states; idle cycles return a changing pattern, not stale data
`timescale 1ns/1ps
`default_nettype none
module mid_mem_model import mid_pkg::*; (
  input  wire logic     mclk,   // E-cycle clock
  input  wire mid_bus_t bus_i,  // Access of this cycle
  output logic [7:0]    rdata   // Read data, same cycle
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_reg;
  // Released bus shows the inverse of the last byte, so stale reads fail
  assign rdata = bus_i.rd ? mem[bus_i.addr] : ~last_reg;
  // Plain always: the bench preloads this array from outside
  always @(posedge mclk) begin
    last_reg <= rdata;
    if (bus_i.wr) begin
      mem[bus_i.addr] <= bus_i.wdata;
    end
  end
  initial begin
    last_reg = 8'h00;
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'hEE;
    end
  end
endmodule : mid_mem_model
`default_nettype wire

// ---- test/mid_core_tb_top.sv ----
// Purpose: self-checking bench for the instruction sequencer
// Assumes: one E-cycle per clock, memory answers in the same cycle
// Notes: outputs sampled at the falling edge, inputs driven at the rising
`timescale 1ns/1ps
`default_nettype none
module mid_core_tb_top import mid_pkg::*;;
  logic mclk, reset_n, irq_req, done, ill, tst, irqu;
  logic [7:0] rdata;
  mid_bus_t bus;
  mid_regs_t regs;
  mid_mode_t mode;
  int err_count = 0;
  int cmp_count = 0;
  mid_core dut (.mclk(mclk), .reset_n(reset_n), .mem_rdata(rdata), .irq_req(irq_req),
    .bus_o(bus), .regs_o(regs), .mode_o(mode), .instr_done_o(done),
    .illegal_op_o(ill), .test_mode_o(tst), .irq_unmasked_o(irqu));
  mid_mem_model mem_u (.mclk(mclk), .bus_i(bus), .rdata(rdata));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task automatic do_reset(input logic [7:0] prog[$]);
    @(posedge mclk);
    reset_n <= 1'b0;
    foreach (prog[i]) mem_u.mem[i] = prog[i];
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    chk("reset pc", 16'h0000, regs.pc);
    chk("reset ccr", {8'h00, CCR_RESET}, {8'h00, regs.ccr});
    chk("reset d", 16'h0000, {regs.a, regs.b});
    @(posedge mclk);
    reset_n <= 1'b1;
  endtask : do_reset
  // Valid codes only in this program
  task automatic t_main;
    logic [15:0] pcs[$];
    int gaps[$];
    mid_regs_t snap[$];
    mid_mode_t mds[$];
    mid_mode_t exp_md[9] = '{immediate_mode, immediate_mode, immediate_mode,
                             base_plus_offset_mode, direct_mode, inherent_mode,
                             extended_mode, pc_offset_mode, pc_offset_mode};
    int n;
    logic [15:0] exp_pc[9] = '{16'h0002, 16'h0004, 16'h0007, 16'h0009, 16'h000B,
                               16'h000C, 16'h000F, 16'h000F, 16'h000F};
    int exp_gap[8] = '{2, 3, 4, 3, 10, 5, 3, 3};
    do_reset('{8'h86, 8'h12, 8'hC6, 8'h34, 8'hCE, 8'h01, 8'h00, 8'hA6, 8'h05,
               8'hD6, 8'h80, 8'h3D, 8'hFF, 8'h02, 8'h00, 8'h20, 8'hFE});
    mem_u.mem[16'h0105] = 8'h56;
    mem_u.mem[16'h0080] = 8'h07;
    irq_req <= 1'b1;
    n = 0;
    for (int i = 0; i < 80 && pcs.size() < 9; i++) begin
      @(negedge mclk);
      n++;
      if (done === 1'b1) begin
        pcs.push_back(regs.pc);
        gaps.push_back(n);
        snap.push_back(regs);
        mds.push_back(mode);
        n = 0;
      end
    end
    if (pcs.size() < 9) begin
      err_count++;
      $display("CHECK FAILED done pulses expected 9 seen %0d", pcs.size());
      stop_test();
    end
    for (int k = 0; k < 9; k++) chk("pc at done", exp_pc[k], pcs[k]);
    for (int k = 0; k < 9; k++) chk("mode", 16'(exp_md[k]), 16'(mds[k]));
    for (int k = 1; k < 9; k++) chk("cycles", 16'(exp_gap[k-1]), 16'(gaps[k]));
    chk("imm d", 16'h1234, {snap[1].a, snap[1].b});
    chk("idx a", 16'h0056, {8'h00, snap[3].a});
    chk("idx x", 16'h0100, snap[3].x);
    chk("dir b", 16'h0007, {8'h00, snap[4].b});
    chk("product d", 16'h025A, {snap[5].a, snap[5].b});
    chk("stx", 16'h0100, {mem_u.mem[16'h0200], mem_u.mem[16'h0201]});
    chk("ccr top", 16'h0003, {14'h0, snap[8].ccr[7:6]});
    chk("irq mask", 16'h0000, {15'h0, irqu});
    $display("test main done");
  endtask : t_main
  task automatic t_test_op;
    logic seen_ill;
    logic [15:0] p0;
    seen_ill = 1'b0;
    do_reset('{8'h03, OP_CLR_I, TEST_OP_B});
    for (int i = 0; i < 20 && tst !== 1'b1; i++) begin
      @(negedge mclk);
      if (ill === 1'b1) seen_ill = 1'b1;
    end
    chk("illegal seen", 16'h0001, {15'h0, seen_ill});
    chk("test mode", 16'h0001, {15'h0, tst});
    chk("irq open", 16'h0001, {15'h0, irqu});
    p0 = regs.pc;
    for (int k = 1; k < 5; k++) begin
      @(negedge mclk);
      chk("free pc", p0 + 16'(k), regs.pc);
    end
    $display("test opcode done");
  endtask : t_test_op
  initial begin
    reset_n = 1'b0;
    irq_req = 1'b0;
    t_main();
    t_test_op();
    stop_test();
  end
endmodule : mid_core_tb_top
`default_nettype wire
